// ==== common/dgr_pkg.sv ====
// Shared constants and types for the DMA global control and request map block
package dgr_pkg;
   localparam int NUM_CHANNELS = 16;
   localparam int ADDR_W = 13;
   localparam int HI_BURST_DEFAULT = 8;
   // Byte offsets relative to the first channel block
   localparam logic [12:0] GLOBAL_BLOCK_BASE = 13'h1000;
   localparam int GLOBAL_SEL_BIT = 12;
   // Global register offsets
   localparam logic [7:0] OFF_ARB_CFG = 8'h00;
   localparam logic [7:0] OFF_PENDING = 8'h04;
   localparam logic [7:0] OFF_THROTTLE = 8'h08;
   localparam logic [7:0] OFF_MASK = 8'h0c;
   localparam logic [7:0] OFF_EVENT = 8'h20;
   // Channel register offsets
   localparam logic [7:0] OFF_CH_CFG = 8'h00;
   localparam logic [7:0] OFF_CH_DESC = 8'h04;
   localparam logic [7:0] OFF_CH_STATP = 8'h08;
   localparam logic [7:0] OFF_CH_BELL = 8'h0c;
   localparam logic [7:0] OFF_CH_FLAG = 8'h10;
   localparam logic [7:0] OFF_CH_STATE = 8'h14;
   localparam logic [7:0] OFF_CH_BYTES = 8'h18;
   // Field positions and widths
   localparam int FETCH_POLICY_BIT = 2;
   localparam int HIGH_POLICY_BIT = 1;
   localparam int LOW_POLICY_BIT = 0;
   localparam int THR_EN_BIT = 31;
   localparam int THR_DIV_W = 16;
   localparam int CH_CFG_W = 10;
   localparam int BYTES_W = 22;
   localparam int DESC_LSB = 5;
   localparam int STATP_LSB = 2;
   localparam int STATE_BELL_BIT = 2;
   localparam int STATE_VALID_BIT = 1;
   localparam int STATE_HALT_BIT = 0;
   // Request source identifiers
   localparam int ID_PIN_A = 4;
   localparam int ID_PIN_B = 5;
   localparam int ID_THROTTLE = 30;
   localparam int ID_ALWAYS = 31;
   // Reset values
   localparam logic [2:0] ARB_CFG_RST = 3'h0;
   localparam logic [15:0] MASK_RST = 16'hffff;
   localparam logic [THR_DIV_W-1:0] THR_DIV_RST = 16'h0000;
   localparam logic [CH_CFG_W-1:0] CH_CFG_RST = 10'h000;

   typedef enum {POOL_HIGH, POOL_LOW} dgr_pool_e;
   typedef struct packed {
      logic valid;
      logic [3:0] idx;
   } dgr_pick_s;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } dgr_bus_s;
endpackage : dgr_pkg

// ==== design/dgr_dma_global.sv ====
// DMA global control, request source map, channel register blocks and arbiter
`timescale 1ns/1ps
// Contract
// - Config bit 2 picks descriptor-fetch policy: 0 round-robin, 1 weighted; resets 0.
// - Config bit 1 picks high-pool policy: 0 round-robin, 1 weighted; resets 0.
// - Config bit 0 picks low-pool policy, resets 0; bits 31:3 reserved.
// - Read-only summary shows every channel flag in bits 15:0, regardless of enable.
// - Throttle enabled by bit 31 requests at bus clock over divider plus one.
// - Throttled periodic request appears as request source 30.
// - Request source 31 is always asserted for unpaced memory transfers.
// - Interrupt enable holds one bit per channel, all set after reset.
// - Enabled channel flags and event status bits are ORed into one interrupt output.
// - Global registers sit at offsets 0x0 to 0xC and 0x20; 0x10 is reserved.
// - Sixteen channel blocks 0x100 apart; offsets above 0x18 reserved.
// - Fixed sources are level, active high; only sources 4 and 5 are programmable.
// - Channel configuration resets to zero with bits 31:10 reserved.
// - Arbiter serves the high pool up to eight times per low-pool turn.
// - Weighted favours lowest channel number; round-robin steps through all requesters.
// - Channel flag sets after an interrupting descriptor and holds until software clears.
module dgr_dma_global #(
   parameter int HI_BURST = dgr_pkg::HI_BURST_DEFAULT
) (
   // Clock and reset
   input wire logic CORE_CLK_IN,
   input wire logic RESET_N_IN,
   // Avalon-MM slave
   input wire logic [dgr_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   // Request sources from peripherals and pins
   input wire logic [31:0] PERIPH_REQ_IN,
   output logic [31:0] REQ_SOURCE_OUT,
   // Transfer engine side
   input wire logic [15:0] CH_FLAG_SET_IN,
   input wire logic [15:0] CH_FETCHED_IN,
   input wire logic [15:0] CH_VALID_IN,
   input wire logic [15:0] CH_HALTED_IN,
   input wire logic [16*dgr_pkg::BYTES_W-1:0] CH_BYTES_IN,
   input wire logic [15:0] HIGH_REQ_IN,
   input wire logic [15:0] LOW_REQ_IN,
   input wire logic [15:0] FETCH_REQ_IN,
   output logic [16*dgr_pkg::CH_CFG_W-1:0] CH_CFG_OUT,
   output logic [16*32-1:0] CH_DESC_PTR_OUT,
   output logic [16*32-1:0] CH_STAT_PTR_OUT,
   output logic [15:0] CH_DOORBELL_OUT,
   output logic [15:0] XFER_GRANT_OUT,
   output logic XFER_GRANT_HIGH_OUT,
   output logic [15:0] FETCH_GRANT_OUT,
   // Interrupt
   output logic IRQ_OUT
);
   import dgr_pkg::*;

   // Burst counter is four bits wide
   if (HI_BURST < 1 || HI_BURST > 15) begin : g_bad_burst
      $error("HI_BURST must lie in 1..15");
   end

   function automatic dgr_pick_s pick(input logic [15:0] req, input logic [3:0] last, input logic weighted);
      dgr_pick_s r;
      logic [3:0] start;
      logic [3:0] k;
      r = '0;
      start = weighted ? 4'h0 : last + 4'h1;
      // Descending scan so the nearest requester at or after start wins
      for (int i = 15; i >= 0; i--) begin
         k = start + i[3:0];
         if (req[k]) begin
            r.valid = 1'b1;
            r.idx = k;
         end
      end
      return r;
   endfunction : pick

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Bus and decode
   dgr_bus_s bus;
   logic waitreq_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rd_data;
   assign bus = '{rd: AVS_READ_IN, wr: AVS_WRITE_IN, addr: AVS_ADDRESS_IN, be: AVS_BYTEENABLE_IN,
                  wdata: AVS_WRITEDATA_IN};
   wire logic wr_do = bus.wr && !waitreq_reg;
   wire logic rd_do = bus.rd && !waitreq_reg;
   wire logic is_global = bus.addr[GLOBAL_SEL_BIT];
   wire logic [3:0] ch = bus.addr[11:8];
   wire logic [7:0] off = {bus.addr[7:2], 2'b00};
   wire logic g_wr = wr_do && is_global;
   wire logic c_wr = wr_do && !is_global;

   // Global registers
   logic [2:0] arb_cfg_reg;
   logic thr_en_reg;
   logic [THR_DIV_W-1:0] thr_div_reg;
   logic [15:0] mask_reg;
   logic [15:0] flag_reg;
   logic [15:0] event_reg;
   logic [31:0] arb_w;
   logic [31:0] thr_w;
   logic [31:0] mask_w;
   assign arb_w = merge({29'h0, arb_cfg_reg}, bus.wdata, bus.be);
   assign thr_w = merge({thr_en_reg, 15'h0, thr_div_reg}, bus.wdata, bus.be);
   assign mask_w = merge({16'h0, mask_reg}, bus.wdata, bus.be);

   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         arb_cfg_reg <= ARB_CFG_RST;
         thr_en_reg <= 1'b0;
         thr_div_reg <= THR_DIV_RST;
         mask_reg <= MASK_RST;
      end else if (g_wr) begin
         if (off == OFF_ARB_CFG) begin
            arb_cfg_reg <= arb_w[2:0];
         end
         if (off == OFF_THROTTLE) begin
            thr_en_reg <= thr_w[THR_EN_BIT];
            thr_div_reg <= thr_w[THR_DIV_W-1:0];
         end
         if (off == OFF_MASK) begin
            mask_reg <= mask_w[15:0];
         end
      end
   end

   // Channel registers
   logic [CH_CFG_W-1:0] cfg_reg [16];
   logic [31:DESC_LSB] desc_reg [16];
   logic [31:STATP_LSB] statp_reg [16];
   logic [15:0] bell_reg;
   logic [31:0] cfg_w;
   logic [31:0] desc_w;
   logic [31:0] statp_w;
   assign cfg_w = merge({22'h0, cfg_reg[ch]}, bus.wdata, bus.be);
   assign desc_w = merge({desc_reg[ch], 5'h00}, bus.wdata, bus.be);
   assign statp_w = merge({statp_reg[ch], 2'h0}, bus.wdata, bus.be);

   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         for (int i = 0; i < 16; i++) begin
            cfg_reg[i] <= CH_CFG_RST;
            desc_reg[i] <= '0;
            statp_reg[i] <= '0;
         end
      end else if (c_wr) begin
         case (off)
            OFF_CH_CFG: begin
               cfg_reg[ch] <= cfg_w[CH_CFG_W-1:0];
            end
            OFF_CH_DESC: begin
               desc_reg[ch] <= desc_w[31:DESC_LSB];
            end
            OFF_CH_STATP: begin
               statp_reg[ch] <= statp_w[31:STATP_LSB];
            end
            default: begin
            end
         endcase
      end
   end

   // Set-wins updates for doorbell, channel flag and event status
   logic [15:0] bell_set;
   logic [15:0] bell_clr;
   logic [15:0] flag_clr;
   logic [15:0] flag_next;
   logic [15:0] event_next;
   wire logic [15:0] ch_hot = 16'h0001 << ch;
   wire logic [7:0] be0_data = bus.wdata[7:0];
   assign bell_set = (c_wr && off == OFF_CH_BELL) ? ch_hot : 16'h0000;
   assign bell_clr = CH_FETCHED_IN |
                     ((c_wr && off == OFF_CH_STATE && bus.be[0] && be0_data[STATE_BELL_BIT]) ? ch_hot : 16'h0000);
   // Writing zero to the flag bit clears it
   assign flag_clr = (c_wr && off == OFF_CH_FLAG && bus.be[0] && !be0_data[0]) ? ch_hot : 16'h0000;
   // flag holds until software clears, hardware set wins
   assign flag_next = (flag_reg & ~flag_clr) | CH_FLAG_SET_IN;
   assign event_next = ((rd_do && is_global && off == OFF_EVENT) ? 16'h0000 : event_reg) | CH_FLAG_SET_IN;

   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         bell_reg <= 16'h0000;
         flag_reg <= 16'h0000;
         event_reg <= 16'h0000;
         IRQ_OUT <= 1'b0;
      end else begin
         bell_reg <= (bell_reg & ~bell_clr) | bell_set;
         flag_reg <= flag_next;
         event_reg <= event_next;
         IRQ_OUT <= |((flag_next | event_next) & mask_reg);
      end
   end

   // Read multiplexer
   logic [31:0] g_rd;
   logic [31:0] c_rd;
   wire logic [BYTES_W-1:0] ch_bytes = CH_BYTES_IN[ch*BYTES_W +: BYTES_W];
   // summary mirrors flags; reserved reads zero
   assign g_rd = (off == OFF_ARB_CFG) ? {29'h0, arb_cfg_reg} :
                 (off == OFF_PENDING) ? {16'h0, flag_reg} :
                 (off == OFF_THROTTLE) ? {thr_en_reg, 15'h0, thr_div_reg} :
                 (off == OFF_MASK) ? {16'h0, mask_reg} :
                 (off == OFF_EVENT) ? {16'h0, event_reg} : 32'h0;
   assign c_rd = (off == OFF_CH_CFG) ? {22'h0, cfg_reg[ch]} :
                 (off == OFF_CH_DESC) ? {desc_reg[ch], 5'h00} :
                 (off == OFF_CH_STATP) ? {statp_reg[ch], 2'h0} :
                 (off == OFF_CH_FLAG) ? {31'h0, flag_reg[ch]} :
                 (off == OFF_CH_STATE) ? {29'h0, bell_reg[ch], CH_VALID_IN[ch], CH_HALTED_IN[ch]} :
                 (off == OFF_CH_BYTES) ? {10'h0, ch_bytes} : 32'h0;
   assign rd_data = is_global ? g_rd : c_rd;

   // One wait state: data is loaded as waitrequest drops
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         waitreq_reg <= 1'b1;
         rdata_reg <= 32'h0;
      end else begin
         waitreq_reg <= !((bus.rd || bus.wr) && waitreq_reg);
         if (bus.rd && waitreq_reg) begin
            rdata_reg <= rd_data;
         end
      end
   end
   assign AVS_WAITREQUEST_OUT = waitreq_reg;
   assign AVS_READDATA_OUT = rdata_reg;

   // Request sources
   logic [31:0] req_meta_reg;
   logic [31:0] req_sync_reg;
   logic [31:0] req_out_reg;
   logic [THR_DIV_W-1:0] thr_cnt_reg;
   wire logic thr_tick = thr_en_reg && (thr_cnt_reg >= thr_div_reg);

   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         req_meta_reg <= 32'h0;
         req_sync_reg <= 32'h0;
         req_out_reg <= 32'h0;
         thr_cnt_reg <= '0;
      end else begin
         req_meta_reg <= PERIPH_REQ_IN;
         req_sync_reg <= req_meta_reg;
         if (!thr_en_reg || thr_tick) begin
            thr_cnt_reg <= '0;
         end else begin
            thr_cnt_reg <= thr_cnt_reg + 16'h0001;
         end
         // level high sources pass unchanged; pins 4 and 5 are shaped per channel downstream
         req_out_reg <= req_sync_reg;
         req_out_reg[ID_THROTTLE] <= thr_tick;
         req_out_reg[ID_ALWAYS] <= 1'b1;
      end
   end
   assign REQ_SOURCE_OUT = req_out_reg;

   // Channel arbiter
   logic [3:0] hi_last_reg;
   logic [3:0] lo_last_reg;
   logic [3:0] fetch_last_reg;
   logic [3:0] hi_count_reg;
   logic [15:0] xfer_grant_reg;
   logic [15:0] fetch_grant_reg;
   logic grant_high_reg;
   dgr_pick_s hi_pick;
   dgr_pick_s lo_pick;
   dgr_pick_s fetch_pick;
   // weighted or round-robin per pool, select
   assign hi_pick = pick(HIGH_REQ_IN, hi_last_reg, arb_cfg_reg[HIGH_POLICY_BIT]);
   assign lo_pick = pick(LOW_REQ_IN, lo_last_reg, arb_cfg_reg[LOW_POLICY_BIT]);
   assign fetch_pick = pick(FETCH_REQ_IN, fetch_last_reg, arb_cfg_reg[FETCH_POLICY_BIT]);
   // high pool up to HI_BURST turns per low turn
   wire logic hi_turn = hi_pick.valid && (hi_count_reg < 4'(HI_BURST) || !lo_pick.valid);

   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         hi_last_reg <= 4'hf;
         lo_last_reg <= 4'hf;
         fetch_last_reg <= 4'hf;
         hi_count_reg <= 4'h0;
         xfer_grant_reg <= 16'h0000;
         fetch_grant_reg <= 16'h0000;
         grant_high_reg <= 1'b0;
      end else begin
         if (hi_turn) begin
            xfer_grant_reg <= 16'h0001 << hi_pick.idx;
            hi_last_reg <= hi_pick.idx;
            grant_high_reg <= 1'b1;
            if (hi_count_reg < 4'(HI_BURST)) begin
               hi_count_reg <= hi_count_reg + 4'h1;
            end
         end else if (lo_pick.valid) begin
            xfer_grant_reg <= 16'h0001 << lo_pick.idx;
            lo_last_reg <= lo_pick.idx;
            grant_high_reg <= 1'b0;
            hi_count_reg <= 4'h0;
         end else begin
            xfer_grant_reg <= 16'h0000;
            grant_high_reg <= 1'b0;
         end
         if (fetch_pick.valid) begin
            fetch_grant_reg <= 16'h0001 << fetch_pick.idx;
            fetch_last_reg <= fetch_pick.idx;
         end else begin
            fetch_grant_reg <= 16'h0000;
         end
      end
   end
   assign XFER_GRANT_OUT = xfer_grant_reg;
   assign XFER_GRANT_HIGH_OUT = grant_high_reg;
   assign FETCH_GRANT_OUT = fetch_grant_reg;
   assign CH_DOORBELL_OUT = bell_reg;

   for (genvar g = 0; g < 16; g++) begin : g_ch_out
      assign CH_CFG_OUT[g*CH_CFG_W +: CH_CFG_W] = cfg_reg[g];
      assign CH_DESC_PTR_OUT[g*32 +: 32] = {desc_reg[g], 5'h00};
      assign CH_STAT_PTR_OUT[g*32 +: 32] = {statp_reg[g], 2'h0};
   end
endmodule : dgr_dma_global

// ==== test/dgr_dma_global_sva.sv ====
// Port-level checker for the DMA global block
`timescale 1ns/1ps
module dgr_dma_global_sva
   import dgr_pkg::*;
#(
   parameter int HI_BURST = 8
) (
   input wire logic CORE_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic [dgr_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_READDATA_OUT,
   input wire logic AVS_WAITREQUEST_OUT,
   input wire logic [31:0] PERIPH_REQ_IN,
   input wire logic [31:0] REQ_SOURCE_OUT,
   input wire logic [15:0] CH_FLAG_SET_IN,
   input wire logic [15:0] HIGH_REQ_IN,
   input wire logic [15:0] LOW_REQ_IN,
   input wire logic [15:0] XFER_GRANT_OUT,
   input wire logic XFER_GRANT_HIGH_OUT,
   input wire logic [15:0] FETCH_GRANT_OUT,
   input wire logic IRQ_OUT
);
   logic [4:0] hi_run_reg;
   logic [4:0] hi_run_next;
   logic flag_any;
   logic acc_done;
   logic resv_hit;
   assign flag_any = |CH_FLAG_SET_IN;
   assign acc_done = (AVS_READ_IN || AVS_WRITE_IN) && !AVS_WAITREQUEST_OUT;
   assign resv_hit = AVS_ADDRESS_IN[12] ? (AVS_ADDRESS_IN[7:0] inside {8'h10, 8'h14, 8'h18, 8'h1c})
                                        : (AVS_ADDRESS_IN[7:0] >= 8'h1c);
   // Saturating run of consecutive high-pool grants
   assign hi_run_next = (XFER_GRANT_OUT == 16'h0) ? hi_run_reg : !XFER_GRANT_HIGH_OUT ? 5'h0 :
                        (hi_run_reg == 5'h1f) ? hi_run_reg : hi_run_reg + 5'h1;
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         hi_run_reg <= 5'h0;
      end else begin
         hi_run_reg <= hi_run_next;
      end
   end
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   sequence bus_taken_q;
      (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
   endsequence
   sequence bus_answer_q;
      !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
   endsequence
   bus_answer_a: assert property (bus_taken_q |=> bus_answer_q)
      else $error("bus answer not one wait cycle");
   resv_zero_a: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT && resv_hit |-> AVS_READDATA_OUT == 32'h0)
      else $error("reserved offset read nonzero");
   always_src_a: assert property ($past(RESET_N_IN) |-> REQ_SOURCE_OUT[31])
      else $error("source 31 not asserted");
   sync_pass_a: assert property (($stable(PERIPH_REQ_IN[29:0]) && $past(RESET_N_IN, 4))[*4]
      |-> REQ_SOURCE_OUT[29:0] == PERIPH_REQ_IN[29:0]) else $error("request map mismatch");
   irq_cause_a: assert property ($rose(IRQ_OUT) |-> $past(flag_any) || $past(flag_any, 2) ||
      $past(acc_done) || $past(acc_done, 2)) else $error("interrupt rose without cause");
   irq_clear_a: assert property ($fell(IRQ_OUT) |-> $past(acc_done) || $past(acc_done, 2))
      else $error("interrupt fell without software access");
   grant_hot_a: assert property ($onehot0(XFER_GRANT_OUT) && $onehot0(FETCH_GRANT_OUT))
      else $error("grant not one-hot");
   high_only_a: assert property (|HIGH_REQ_IN && LOW_REQ_IN == 16'h0 |=> XFER_GRANT_HIGH_OUT &&
      (XFER_GRANT_OUT & $past(HIGH_REQ_IN)) != 16'h0) else $error("high request not granted");
   low_turn_a: assert property (hi_run_reg >= HI_BURST - 1 && XFER_GRANT_HIGH_OUT && XFER_GRANT_OUT != 16'h0
      && |LOW_REQ_IN |=> !XFER_GRANT_HIGH_OUT && XFER_GRANT_OUT != 16'h0) else $error("low pool starved");
endmodule : dgr_dma_global_sva

bind dgr_dma_global dgr_dma_global_sva #(.HI_BURST(HI_BURST)) u_sva (.CORE_CLK_IN(CORE_CLK_IN),
   .RESET_N_IN(RESET_N_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
   .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
   .PERIPH_REQ_IN(PERIPH_REQ_IN), .REQ_SOURCE_OUT(REQ_SOURCE_OUT), .CH_FLAG_SET_IN(CH_FLAG_SET_IN),
   .HIGH_REQ_IN(HIGH_REQ_IN), .LOW_REQ_IN(LOW_REQ_IN), .XFER_GRANT_OUT(XFER_GRANT_OUT),
   .XFER_GRANT_HIGH_OUT(XFER_GRANT_HIGH_OUT), .FETCH_GRANT_OUT(FETCH_GRANT_OUT), .IRQ_OUT(IRQ_OUT));

// ==== test/dgr_periph_model.sv ====
// Peripheral side: level requests and descriptor-done pulses
`timescale 1ns/1ps
module dgr_periph_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [31:0] level_in,
   input wire logic [15:0] done_in,
   output logic [31:0] req_out,
   output logic [15:0] done_out
);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_out <= 32'h0;
         done_out <= 16'h0;
      end else begin
         req_out <= level_in;
         done_out <= done_in & ~done_out;
      end
   end
endmodule : dgr_periph_model

// ==== test/dgr_dma_global_bench.sv ====
// Self-checking bench for the DMA global block
`timescale 1ns/1ps
module dgr_dma_global_bench;
   import dgr_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [31:0] wdata = '0, rdo, rdata, lvl = '0, preq, src;
   logic [15:0] done = '0, hreq = '0, lreq = '0, freq = '0, flag, grant, fgrant;
   logic [16*CH_CFG_W-1:0] cfgo;
   logic [16*32-1:0] dptr, sptr;
   logic [15:0] bell, fetched = '0, chst = '0;
   logic irq, ghigh, waitr;
   int n_errors = 0;
   int checks_done = 0;
   initial begin
      forever #2 clk = ~clk;
   end
   dgr_periph_model PM (.clk_in(clk), .rst_n_in(rst_n), .level_in(lvl), .done_in(done), .req_out(preq),
      .done_out(flag));
   dgr_dma_global #(.HI_BURST(8)) DUT (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
      .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(4'hf), .AVS_WRITEDATA_IN(wdata),
      .AVS_READDATA_OUT(rdo), .AVS_WAITREQUEST_OUT(waitr), .PERIPH_REQ_IN(preq), .REQ_SOURCE_OUT(src),
      .CH_FLAG_SET_IN(flag), .CH_FETCHED_IN(fetched), .CH_VALID_IN(chst), .CH_HALTED_IN(~chst),
      .CH_BYTES_IN('0), .HIGH_REQ_IN(hreq), .LOW_REQ_IN(lreq), .FETCH_REQ_IN(freq), .CH_CFG_OUT(cfgo),
      .CH_DESC_PTR_OUT(dptr), .CH_STAT_PTR_OUT(sptr), .CH_DOORBELL_OUT(bell), .XFER_GRANT_OUT(grant),
      .XFER_GRANT_HIGH_OUT(ghigh), .FETCH_GRANT_OUT(fgrant), .IRQ_OUT(irq));
   task automatic print_verdict();
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [12:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitr !== 1'b0 && n < 100);
      rdata = rdo;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 100) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, waitr, 1'b0);
      end
   endtask : bus
   task automatic rdchk(input logic [12:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdata, exp);
   endtask : rdchk
   task automatic set_req(input logic [15:0] h, input logic [15:0] l, input logic [15:0] f);
      @(posedge clk);
      hreq <= h;
      lreq <= l;
      freq <= f;
      cyc(3);
   endtask : set_req
   task automatic cnt30(input int n, input int exp);
      int c;
      c = 0;
      repeat (n) begin
         @(posedge clk);
         if (src[30] === 1'b1) c++;
      end
      chk(c, exp);
   endtask : cnt30
   task automatic t_reset();
      rdchk(13'h1000, 32'h0);
      rdchk(13'h1004, 32'h0);
      rdchk(13'h1008, 32'h0);
      rdchk(13'h100c, 32'h0000ffff);
      rdchk(13'h0f00, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_map();
      bus(1'b1, 13'h1000, 32'hffffffff);
      rdchk(13'h1000, 32'h7);
      bus(1'b1, 13'h0f00, 32'hffffffff);
      rdchk(13'h0f00, 32'h3ff);
      chk({22'h0, cfgo[15*CH_CFG_W +: CH_CFG_W]}, 32'h3ff);
      rdchk(13'h0e00, 32'h0);
      bus(1'b1, 13'h1010, 32'hffffffff);
      rdchk(13'h1010, 32'h0);
      bus(1'b1, 13'h0f1c, 32'hffffffff);
      rdchk(13'h0f1c, 32'h0);
      bus(1'b1, 13'h0f00, 32'h0);
      $display("test map done");
   endtask : t_map
   task automatic t_chan();
      bus(1'b1, 13'h0204, 32'h12345678);
      rdchk(13'h0204, 32'h12345660);
      chk(dptr[2*32 +: 32], 32'h12345660);
      bus(1'b1, 13'h0208, 32'habcdef07);
      rdchk(13'h0208, 32'habcdef04);
      chk(sptr[2*32 +: 32], 32'habcdef04);
      @(posedge clk);
      chst <= 16'h0020;
      bus(1'b1, 13'h050c, 32'h1);
      rdchk(13'h0514, 32'h6);
      rdchk(13'h0414, 32'h1);
      chk({16'h0, bell}, 32'h20);
      @(posedge clk);
      fetched <= 16'h0020;
      @(posedge clk);
      fetched <= 16'h0;
      cyc(1);
      chk({16'h0, bell}, 32'h0);
      bus(1'b1, 13'h050c, 32'h1);
      bus(1'b1, 13'h0514, 32'h4);
      rdchk(13'h0514, 32'h2);
      $display("test channel done");
   endtask : t_chan
   task automatic t_irq();
      @(posedge clk);
      done <= 16'h0008;
      @(posedge clk);
      done <= 16'h0;
      cyc(4);
      chk({31'h0, irq}, 32'h1);
      rdchk(13'h1004, 32'h8);
      bus(1'b1, 13'h100c, 32'hfff7);
      cyc(3);
      chk({31'h0, irq}, 32'h0);
      rdchk(13'h1004, 32'h8);
      bus(1'b1, 13'h100c, 32'hffff);
      bus(1'b1, 13'h0310, 32'h0);
      rdchk(13'h1004, 32'h0);
      rdchk(13'h1020, 32'h8);
      cyc(3);
      chk({31'h0, irq}, 32'h0);
      $display("test irq done");
   endtask : t_irq
   task automatic t_thr();
      bus(1'b1, 13'h1008, 32'h80000003);
      rdchk(13'h1008, 32'h80000003);
      cyc(5);
      cnt30(40, 10);
      bus(1'b1, 13'h1008, 32'h80000000);
      cyc(5);
      cnt30(12, 12);
      bus(1'b1, 13'h1008, 32'h0);
      cyc(5);
      cnt30(12, 0);
      $display("test throttle done");
   endtask : t_thr
   task automatic t_src();
      @(posedge clk);
      lvl <= 32'hc5a53c0f;
      cyc(8);
      chk(src, 32'h85a53c0f);
      @(posedge clk);
      lvl <= 32'h3ffffff0;
      cyc(8);
      chk(src, 32'hbffffff0);
      $display("test sources done");
   endtask : t_src
   task automatic t_arb();
      int c0;
      int c1;
      bus(1'b1, 13'h1000, 32'h2);
      set_req(16'h000a, 16'h0, 16'h0);
      chk({16'h0, grant}, 32'h2);
      chk({31'h0, ghigh}, 32'h1);
      bus(1'b1, 13'h1000, 32'h0);
      set_req(16'h0003, 16'h0, 16'h0);
      c0 = 0;
      c1 = 0;
      repeat (8) begin
         @(posedge clk);
         c0 += (grant === 16'h1);
         c1 += (grant === 16'h2);
      end
      chk(c0 * 16 + c1, 32'h44);
      bus(1'b1, 13'h1000, 32'h1);
      set_req(16'h0, 16'h0006, 16'h0);
      chk({16'h0, grant}, 32'h2);
      bus(1'b1, 13'h1000, 32'h0);
      set_req(16'h0001, 16'h0001, 16'h0);
      c0 = 0;
      repeat (18) begin
         @(posedge clk);
         c0 += (ghigh === 1'b0 && grant === 16'h1);
      end
      chk(c0, 32'h2);
      bus(1'b1, 13'h1000, 32'h4);
      set_req(16'h0, 16'h0, 16'h000c);
      chk({16'h0, fgrant}, 32'h4);
      set_req(16'h0, 16'h0, 16'h0);
      $display("test arbiter done");
   endtask : t_arb
   initial begin
      cyc(3);
      rst_n <= 1'b1;
      t_reset();
      t_map();
      t_chan();
      t_irq();
      t_thr();
      t_src();
      t_arb();
      print_verdict();
   end
   initial begin
      #20000;
      n_errors++;
      print_verdict();
   end
endmodule : dgr_dma_global_bench
